// >>> common/rcr_pkg.sv
// Contract
// - decode 256 byte locations from a configurable base; registers at fixed offsets
// - pin level registers return present pin levels; writes have no effect
// - ports A/B mode bit: 0 general I/O, 1 latched address out; readable
// - output level register drives pins, reads back; cell-driven pins ignore it
// - direction bit 1 makes pin output, 0 input; readable
// - drive type bit picks open-drain or high slew; readable; push-pull at reset
// - input cell registers return input cell state; writes ignored
// - driver-enabled registers report 1 for enabled drivers, 0 for off; read-only
// - output cell bank read returns cell outputs; write loads cell flip-flops
// - mask bit 1 blocks cell read and write, 0 passes; masks readable
// - main flash protection register is read-only configured setting
// - security register reads secured bit and secondary flash protection
// - first and second power registers are writable and readable
// - third power register bit 1 cleared only by reset, never by write
// - memory page register is writable and readable
// - memory placement register overrides configured setting; reset restores it
package rcr_pkg;
    localparam logic [7:0] OFS_A_PIN   = 8'h00;
    localparam logic [7:0] OFS_B_PIN   = 8'h01;
    localparam logic [7:0] OFS_A_MODE  = 8'h02;
    localparam logic [7:0] OFS_B_MODE  = 8'h03;
    localparam logic [7:0] OFS_A_OUT   = 8'h04;
    localparam logic [7:0] OFS_B_OUT   = 8'h05;
    localparam logic [7:0] OFS_A_DIR   = 8'h06;
    localparam logic [7:0] OFS_B_DIR   = 8'h07;
    localparam logic [7:0] OFS_A_DRV   = 8'h08;
    localparam logic [7:0] OFS_B_DRV   = 8'h09;
    localparam logic [7:0] OFS_A_ICELL = 8'h0A;
    localparam logic [7:0] OFS_B_ICELL = 8'h0B;
    localparam logic [7:0] OFS_A_OEN   = 8'h0C;
    localparam logic [7:0] OFS_B_OEN   = 8'h0D;
    localparam logic [7:0] OFS_C_PIN   = 8'h10;
    localparam logic [7:0] OFS_D_PIN   = 8'h11;
    localparam logic [7:0] OFS_C_OUT   = 8'h12;
    localparam logic [7:0] OFS_D_OUT   = 8'h13;
    localparam logic [7:0] OFS_C_DIR   = 8'h14;
    localparam logic [7:0] OFS_D_DIR   = 8'h15;
    localparam logic [7:0] OFS_C_DRV   = 8'h16;
    localparam logic [7:0] OFS_D_DRV   = 8'h17;
    localparam logic [7:0] OFS_C_ICELL = 8'h18;
    localparam logic [7:0] OFS_C_OEN   = 8'h1A;
    localparam logic [7:0] OFS_D_OEN   = 8'h1B;
    localparam logic [7:0] OFS_CELL1   = 8'h20;
    localparam logic [7:0] OFS_CELL2   = 8'h21;
    localparam logic [7:0] OFS_MASK1   = 8'h22;
    localparam logic [7:0] OFS_MASK2   = 8'h23;
    localparam logic [7:0] OFS_PWR1    = 8'hB0;
    localparam logic [7:0] OFS_PWR2    = 8'hB4;
    localparam logic [7:0] OFS_MPROT   = 8'hC0;
    localparam logic [7:0] OFS_SEC     = 8'hC2;
    localparam logic [7:0] OFS_PWR3    = 8'hC7;
    localparam logic [7:0] OFS_PAGE    = 8'hE0;
    localparam logic [7:0] OFS_PLACE   = 8'hE2;
    // reset values of the writable registers
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [7:0] RST_DRV     = 8'h00; // push-pull everywhere
    // bit of the third power register that only reset clears
    localparam int         PWR3_STICKY = 1;
    // one byte-wide bus request from the core
    typedef struct packed {
        logic       sel;   // chip select of the whole window
        logic       rd;
        logic       wr;
        logic [7:0] ofs;
        logic [7:0] wdata;
    } bus_req_t;
endpackage

// >>> hdl/runtime_control_register_block.sv
// byte register window for the processor core; port, cell and power
// registers are held here, the logic they steer lives outside
// read data is registered: it appears one edge after the strobe
// unused offsets ignore writes and read as zero
// only the upper address byte selects the window; the base is the BASE_ADDR parameter
// status inputs cross in through two flops, so their reads lag by two
module runtime_control_register_block #(
    parameter logic [15:0] BASE_ADDR = 16'h0000
) (
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST_N,

    // processor byte bus
    input  wire logic [15:0] ADDR,
    input  wire logic        RD,
    input  wire logic        WR,
    input  wire logic [7:0]  WDATA,
    output logic      [7:0]  RDATA,

    // port pins (ports A..D, 8 bits each)
    input  wire logic [7:0]  PIN_A,
    input  wire logic [7:0]  PIN_B,
    input  wire logic [7:0]  PIN_C,
    input  wire logic [7:0]  PIN_D,
    output logic      [7:0]  OUT_A,
    output logic      [7:0]  OUT_B,
    output logic      [7:0]  OUT_C,
    output logic      [7:0]  OUT_D,
    output logic      [7:0]  DIR_A,
    output logic      [7:0]  DIR_B,
    output logic      [7:0]  DIR_C,
    output logic      [7:0]  DIR_D,
    output logic      [7:0]  DRV_A,
    output logic      [7:0]  DRV_B,
    output logic      [7:0]  DRV_C,
    output logic      [7:0]  DRV_D,
    output logic      [7:0]  MODE_A,
    output logic      [7:0]  MODE_B,

    // status from the port drivers and logic array
    input  wire logic [7:0]  CELL_DRIVES_A,
    input  wire logic [7:0]  CELL_DRIVES_B,
    input  wire logic [7:0]  CELL_DRIVES_C,
    input  wire logic [7:0]  CELL_DRIVES_D,
    input  wire logic [7:0]  DRV_EN_A,
    input  wire logic [7:0]  DRV_EN_B,
    input  wire logic [7:0]  DRV_EN_C,
    input  wire logic [7:0]  DRV_EN_D,
    input  wire logic [7:0]  ICELL_A,
    input  wire logic [7:0]  ICELL_B,
    input  wire logic [7:0]  ICELL_C,

    // output logic cells: present state in, masked load out
    input  wire logic [7:0]  OCELL1_Q,
    input  wire logic [7:0]  OCELL2_Q,
    output logic      [7:0]  OCELL1_LOAD,
    output logic      [7:0]  OCELL2_LOAD,
    output logic      [7:0]  OCELL_DATA,

    // non-volatile settings
    input  wire logic [7:0]  NV_MAIN_PROT,
    input  wire logic [7:0]  NV_SEC_PROT,
    input  wire logic [7:0]  NV_PLACE,

    // power, page and placement
    output logic      [7:0]  PWR1,
    output logic      [7:0]  PWR2,
    output logic      [7:0]  PWR3,
    output logic      [7:0]  PAGE,
    output logic      [7:0]  PLACE
);

    rcr_pkg::bus_req_t req;

    // window decode: upper address byte must match the base
    assign req.sel   = (ADDR[15:8] == BASE_ADDR[15:8]);
    assign req.rd    = RD;
    assign req.wr    = WR;
    assign req.ofs   = ADDR[7:0];
    assign req.wdata = WDATA;

    // a strobe outside the window is ignored entirely
    wire logic wr_go = req.sel & req.wr; // one byte per cycle

    // pin and status inputs come from outside the clock domain
    logic [7:0] s1 [0:14];
    logic [7:0] s2 [0:14];
    wire  logic [7:0] raw [0:14];
    // pin levels of the four ports
    assign raw[0]  = PIN_A;
    assign raw[1]  = PIN_B;
    assign raw[2]  = PIN_C;
    assign raw[3]  = PIN_D;

    // input cell state
    assign raw[4]  = ICELL_A;
    assign raw[5]  = ICELL_B;
    assign raw[6]  = ICELL_C;

    // driver enable status
    assign raw[7]  = DRV_EN_A;
    assign raw[8]  = DRV_EN_B;
    assign raw[9]  = DRV_EN_C;
    assign raw[10] = DRV_EN_D;

    // which port pins an output cell owns
    assign raw[11] = CELL_DRIVES_A;
    assign raw[12] = CELL_DRIVES_B;
    assign raw[13] = CELL_DRIVES_C;
    assign raw[14] = CELL_DRIVES_D;

    // the first flop may go metastable, so only the second reads it
    genvar g;
    generate
        for (g = 0; g < 15; g++) begin : gsync
            always_ff @(posedge MCLK or negedge RST_N) begin
                if (!RST_N) begin
                    s1[g] <= rcr_pkg::RST_ZERO;
                    s2[g] <= rcr_pkg::RST_ZERO;
                end else begin
                    s1[g] <= raw[g];
                    s2[g] <= s1[g];
                end
            end
        end
    endgenerate

    // writable registers, indexed by port
    logic [7:0] out_r [0:3];
    logic [7:0] dir_r [0:3];
    logic [7:0] drv_r [0:3];
    logic [7:0] mode_r [0:1];
    // cell masks: a set bit hides and protects that cell
    logic [7:0] mask1_r;
    logic [7:0] mask2_r;
    // power registers; the power logic reads them directly
    logic [7:0] pwr1_r;
    logic [7:0] pwr2_r;
    logic [7:0] pwr3_r;
    // memory page and placement
    logic [7:0] page_r;
    logic [7:0] place_r;
    // set by the first placement write, cleared only by reset
    logic       place_ld_r;

    // per-port register writes; offsets differ between A/B and C/D
    wire logic [7:0] ofs_out [0:3];
    wire logic [7:0] ofs_dir [0:3];
    wire logic [7:0] ofs_drv [0:3];
    assign ofs_out[0] = rcr_pkg::OFS_A_OUT;
    assign ofs_out[1] = rcr_pkg::OFS_B_OUT;
    assign ofs_out[2] = rcr_pkg::OFS_C_OUT;
    assign ofs_out[3] = rcr_pkg::OFS_D_OUT;

    // direction offsets
    assign ofs_dir[0] = rcr_pkg::OFS_A_DIR;
    assign ofs_dir[1] = rcr_pkg::OFS_B_DIR;
    assign ofs_dir[2] = rcr_pkg::OFS_C_DIR;
    assign ofs_dir[3] = rcr_pkg::OFS_D_DIR;

    // drive type offsets
    assign ofs_drv[0] = rcr_pkg::OFS_A_DRV;
    assign ofs_drv[1] = rcr_pkg::OFS_B_DRV;
    assign ofs_drv[2] = rcr_pkg::OFS_C_DRV;
    assign ofs_drv[3] = rcr_pkg::OFS_D_DRV;

    generate
        for (g = 0; g < 4; g++) begin : gport
            always_ff @(posedge MCLK or negedge RST_N) begin
                if (!RST_N) begin
                    out_r[g] <= rcr_pkg::RST_ZERO;
                    dir_r[g] <= rcr_pkg::RST_ZERO;
                    drv_r[g] <= rcr_pkg::RST_DRV;
                end else begin
                    if (wr_go && req.ofs == ofs_out[g])
                        out_r[g] <= req.wdata;
                    if (wr_go && req.ofs == ofs_dir[g])
                        dir_r[g] <= req.wdata;
                    if (wr_go && req.ofs == ofs_drv[g])
                        drv_r[g] <= req.wdata;
                end
            end
        end
    endgenerate

    // mode, mask, power, page and placement registers
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            // configuration registers
            mode_r[0]  <= rcr_pkg::RST_ZERO;
            mode_r[1]  <= rcr_pkg::RST_ZERO;
            mask1_r    <= rcr_pkg::RST_ZERO;
            mask2_r    <= rcr_pkg::RST_ZERO;
            // power and memory registers
            pwr1_r     <= rcr_pkg::RST_ZERO;
            pwr2_r     <= rcr_pkg::RST_ZERO;
            pwr3_r     <= rcr_pkg::RST_ZERO;
            page_r     <= rcr_pkg::RST_ZERO;
            place_r    <= rcr_pkg::RST_ZERO;
            place_ld_r <= 1'b0;
        end else begin
            // ports A and B: address-out mode per pin
            if (wr_go && req.ofs == rcr_pkg::OFS_A_MODE)
                mode_r[0] <= req.wdata;
            if (wr_go && req.ofs == rcr_pkg::OFS_B_MODE)
                mode_r[1] <= req.wdata;

            // cell masks take effect on the next access
            if (wr_go && req.ofs == rcr_pkg::OFS_MASK1)
                mask1_r <= req.wdata;
            if (wr_go && req.ofs == rcr_pkg::OFS_MASK2)
                mask2_r <= req.wdata;

            // first two power registers are plain bytes
            if (wr_go && req.ofs == rcr_pkg::OFS_PWR1)
                pwr1_r <= req.wdata;
            if (wr_go && req.ofs == rcr_pkg::OFS_PWR2)
                pwr2_r <= req.wdata;

            // writes may set the sticky bit but never clear it
            if (wr_go && req.ofs == rcr_pkg::OFS_PWR3) begin
                pwr3_r <= req.wdata;
                pwr3_r[rcr_pkg::PWR3_STICKY] <=
                    req.wdata[rcr_pkg::PWR3_STICKY] |
                    pwr3_r[rcr_pkg::PWR3_STICKY];
            end

            // page used by paged memory decoding
            if (wr_go && req.ofs == rcr_pkg::OFS_PAGE)
                page_r <= req.wdata;

            // placement follows the configured setting until first written
            if (wr_go && req.ofs == rcr_pkg::OFS_PLACE) begin
                place_r    <= req.wdata;
                place_ld_r <= 1'b1;
            end else if (!place_ld_r)
                place_r <= NV_PLACE;
        end
    end

    // masked cell loads: a set mask bit keeps that cell unchanged
    // the load is a one-cycle pulse per bit, data travels beside it
    wire logic [7:0] ld1_nxt = (wr_go && req.ofs == rcr_pkg::OFS_CELL1) ?
                               ~mask1_r : 8'h00;
    wire logic [7:0] ld2_nxt = (wr_go && req.ofs == rcr_pkg::OFS_CELL2) ?
                               ~mask2_r : 8'h00;

    // read multiplexer; cell reads show zero where masked
    logic [7:0] rd_nxt;
    always_comb begin
        rd_nxt = 8'h00;
        case (req.ofs)
            // pin levels, two edges behind the pins
            rcr_pkg::OFS_A_PIN:   rd_nxt = s2[0];
            rcr_pkg::OFS_B_PIN:   rd_nxt = s2[1];
            rcr_pkg::OFS_C_PIN:   rd_nxt = s2[2];
            rcr_pkg::OFS_D_PIN:   rd_nxt = s2[3];

            // port configuration reads back as written
            rcr_pkg::OFS_A_MODE:  rd_nxt = mode_r[0];
            rcr_pkg::OFS_B_MODE:  rd_nxt = mode_r[1];
            rcr_pkg::OFS_A_OUT:   rd_nxt = out_r[0];
            rcr_pkg::OFS_B_OUT:   rd_nxt = out_r[1];
            rcr_pkg::OFS_C_OUT:   rd_nxt = out_r[2];
            rcr_pkg::OFS_D_OUT:   rd_nxt = out_r[3];
            rcr_pkg::OFS_A_DIR:   rd_nxt = dir_r[0];
            rcr_pkg::OFS_B_DIR:   rd_nxt = dir_r[1];
            rcr_pkg::OFS_C_DIR:   rd_nxt = dir_r[2];
            rcr_pkg::OFS_D_DIR:   rd_nxt = dir_r[3];
            rcr_pkg::OFS_A_DRV:   rd_nxt = drv_r[0];
            rcr_pkg::OFS_B_DRV:   rd_nxt = drv_r[1];
            rcr_pkg::OFS_C_DRV:   rd_nxt = drv_r[2];
            rcr_pkg::OFS_D_DRV:   rd_nxt = drv_r[3];

            // synchronised cell and driver status
            rcr_pkg::OFS_A_ICELL: rd_nxt = s2[4];
            rcr_pkg::OFS_B_ICELL: rd_nxt = s2[5];
            rcr_pkg::OFS_C_ICELL: rd_nxt = s2[6];
            rcr_pkg::OFS_A_OEN:   rd_nxt = s2[7];
            rcr_pkg::OFS_B_OEN:   rd_nxt = s2[8];
            rcr_pkg::OFS_C_OEN:   rd_nxt = s2[9];
            rcr_pkg::OFS_D_OEN:   rd_nxt = s2[10];

            // output cells and their masks
            rcr_pkg::OFS_CELL1:   rd_nxt = OCELL1_Q & ~mask1_r;
            rcr_pkg::OFS_CELL2:   rd_nxt = OCELL2_Q & ~mask2_r;
            rcr_pkg::OFS_MASK1:   rd_nxt = mask1_r;
            rcr_pkg::OFS_MASK2:   rd_nxt = mask2_r;

            // power, protection, page and placement
            rcr_pkg::OFS_PWR1:    rd_nxt = pwr1_r;
            rcr_pkg::OFS_PWR2:    rd_nxt = pwr2_r;
            rcr_pkg::OFS_MPROT:   rd_nxt = NV_MAIN_PROT;
            rcr_pkg::OFS_SEC:     rd_nxt = NV_SEC_PROT;
            rcr_pkg::OFS_PWR3:    rd_nxt = pwr3_r;
            rcr_pkg::OFS_PAGE:    rd_nxt = page_r;
            rcr_pkg::OFS_PLACE:   rd_nxt = place_r;

            // offsets with no register read as zero
            default:              rd_nxt = 8'h00;
        endcase
        // no strobe or outside the window: the byte stays zero
        if (!(req.sel && req.rd))
            rd_nxt = 8'h00;
    end

    // pins driven by an output cell ignore the output register
    // ownership comes through the synchroniser, so it lags two edges
    wire logic [7:0] outq [0:3];
    generate
        for (g = 0; g < 4; g++) begin : gmask
            assign outq[g] = out_r[g] & ~s2[11 + g];
        end
    endgenerate

    // registered outputs; read data lags the request by one edge
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA       <= 8'h00;
            OUT_A       <= 8'h00;
            OUT_B       <= 8'h00;
            OUT_C       <= 8'h00;
            OUT_D       <= 8'h00;
            OCELL1_LOAD <= 8'h00;
            OCELL2_LOAD <= 8'h00;
            OCELL_DATA  <= 8'h00;
        end else begin
            // read byte for the core
            RDATA       <= rd_nxt;

            // port levels, cell-owned pins forced low
            OUT_A       <= outq[0];
            OUT_B       <= outq[1];
            OUT_C       <= outq[2];
            OUT_D       <= outq[3];

            // one-cycle load pulse and its data
            OCELL1_LOAD <= ld1_nxt;
            OCELL2_LOAD <= ld2_nxt;
            OCELL_DATA  <= req.wdata;
        end
    end

    // configuration outputs are the registers themselves
    assign DIR_A  = dir_r[0];
    assign DIR_B  = dir_r[1];
    assign DIR_C  = dir_r[2];
    assign DIR_D  = dir_r[3];

    // drive type per pin: open-drain or slew, push-pull at reset
    assign DRV_A  = drv_r[0];
    assign DRV_B  = drv_r[1];
    assign DRV_C  = drv_r[2];
    assign DRV_D  = drv_r[3];

    // address-out mode for ports A and B
    assign MODE_A = mode_r[0];
    assign MODE_B = mode_r[1];

    // power, page and placement feed the memory and clock logic
    assign PWR1   = pwr1_r;
    assign PWR2   = pwr2_r;
    assign PWR3   = pwr3_r;
    assign PAGE   = page_r;
    assign PLACE  = place_r;

endmodule

// >>> verif/rcr_core_model.sv
// processor side: turns one byte request of the bench into bus levels
module rcr_core_model #(
    parameter logic [15:0] BASE_ADDR = 16'h0000
) (
    // clock and request
    input  wire logic              MCLK,
    input  wire rcr_pkg::bus_req_t req,
    // processor byte bus
    output logic [15:0]            ADDR,
    output logic                   RD,
    output logic                   WR,
    output logic [7:0]             WDATA
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] churn_r = 8'hA5;
    // idle lines change every cycle so a stale byte never looks valid
    always_ff @(posedge MCLK) churn_r <= ~churn_r;
    // a deselected cycle points outside the window
    assign ADDR  = req.sel ? {BASE_ADDR[15:8], req.ofs}
                           : {~BASE_ADDR[15:8], churn_r};
    // one byte strobe per request, data only while writing
    assign RD    = req.rd;
    assign WR    = req.wr;
    assign WDATA = req.wr ? req.wdata : churn_r;
endmodule

// >>> verif/rcr_chk.sv
// watches the register window from its ports alone
module rcr_chk #(
    parameter logic [15:0] BASE_ADDR = 16'h0000
) (
    // clock, reset and byte bus
    input wire logic        MCLK,
    input wire logic        RST_N,
    input wire logic [15:0] ADDR,
    input wire logic        RD,
    input wire logic        WR,
    input wire logic [7:0]  WDATA,
    input wire logic [7:0]  RDATA,
    // port, cell and configuration signals
    input wire logic [7:0]  PIN_A,
    input wire logic [7:0]  CELL_DRIVES_A,
    input wire logic [7:0]  OUT_A,
    input wire logic [7:0]  OCELL1_Q,
    input wire logic [7:0]  OCELL1_LOAD,
    input wire logic [7:0]  NV_MAIN_PROT,
    input wire logic [7:0]  NV_PLACE,
    input wire logic [7:0]  PWR3,
    input wire logic [7:0]  PAGE,
    input wire logic [7:0]  PLACE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    logic [1:0]      settle_r;
    wire logic [7:0] ofs    = ADDR[7:0];
    wire logic       rd_hit = RD && ADDR[15:8] == BASE_ADDR[15:8];
    wire logic       wr_hit = WR && ADDR[15:8] == BASE_ADDR[15:8];
    // synchronised inputs are only trusted two edges after reset
    always_ff @(posedge MCLK or negedge RST_N)
        if (!RST_N) settle_r <= 2'h0;
        else if (!settle_r[1]) settle_r <= settle_r + 2'h1;
    sequence pin_rd_s;
        $stable(PIN_A) [*3] ##0 rd_hit && ofs == 8'h00 && settle_r[1];
    endsequence
    sequence out_wr_s;
        $stable(CELL_DRIVES_A) [*3] ##0 wr_hit && ofs == 8'h04 && settle_r[1];
    endsequence
    idle_read_a: assert property ((!rd_hit || ofs > 8'hE2)
        |=> RDATA == 8'h00) else $error("read data not zero");
    pin_read_a: assert property (pin_rd_s
        |=> RDATA == $past(PIN_A)) else $error("pin level read wrong");
    out_drive_a: assert property (out_wr_s
        |=> ##1 OUT_A == ($past(WDATA, 2) & ~$past(CELL_DRIVES_A, 2)))
        else $error("driven level wrong");
    cell_load_a: assert property (!(wr_hit && ofs == 8'h20)
        |=> OCELL1_LOAD == 8'h00) else $error("stray cell load");
    cell_mask_a: assert property (rd_hit && ofs == 8'h20
        |=> (RDATA & ~$past(OCELL1_Q)) == 8'h00) else $error("cell read wrong");
    prot_read_a: assert property (rd_hit && ofs == 8'hC0
        |=> RDATA == $past(NV_MAIN_PROT)) else $error("protection read wrong");
    sticky_bit_a: assert property (PWR3[1] |=> PWR3[1])
        else $error("sticky power bit cleared");
    page_write_a: assert property (wr_hit && ofs == 8'hE0
        |=> PAGE == $past(WDATA)) else $error("page not written");
    place_reset_a: assert property ($rose(RST_N)
        && !(wr_hit && ofs == 8'hE2) |=> PLACE == $past(NV_PLACE))
        else $error("placement not restored");
endmodule

bind runtime_control_register_block rcr_chk #(.BASE_ADDR(BASE_ADDR)) rcr_chk_inst (
    .MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .RD(RD), .WR(WR),
    .WDATA(WDATA), .RDATA(RDATA), .PIN_A(PIN_A),
    .CELL_DRIVES_A(CELL_DRIVES_A), .OUT_A(OUT_A), .OCELL1_Q(OCELL1_Q),
    .OCELL1_LOAD(OCELL1_LOAD), .NV_MAIN_PROT(NV_MAIN_PROT),
    .NV_PLACE(NV_PLACE), .PWR3(PWR3), .PAGE(PAGE), .PLACE(PLACE));

// >>> verif/runtime_control_register_block_bench.sv
module runtime_control_register_block_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] BASE = 16'h3A00;
    `define CHK(got, exp) begin \
        compares++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("[ERR] %0t got %h exp %h", $time, got, exp); \
        end \
    end
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    rcr_pkg::bus_req_t req = '0;
    logic [15:0]       addr;
    logic              rd, wr;
    logic [7:0]        wdata, rdata, rbyte, load1, load2, cdata;
    logic [7:0]        st[20];
    logic [7:0]        outs[19];
    logic [7:0]        seed = 8'h1B;
    int                mdl[256];
    int                errors = 0;
    int                compares = 0;
    // read-only offsets in the order of st, writable ones in that of outs
    logic [7:0] ro_ofs[13] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h0A, 8'h0B,
        8'h18, 8'h0C, 8'h0D, 8'h1A, 8'h1B, 8'hC0, 8'hC2};
    logic [7:0] rw_ofs[21] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h08, 8'h09, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'hB0,
        8'hB4, 8'hC7, 8'hE0, 8'hE2, 8'h22, 8'h23};
    initial forever #12.5 mclk = ~mclk;
    rcr_core_model #(.BASE_ADDR(BASE)) rcr_core_model_inst (
        .MCLK(mclk), .req(req), .ADDR(addr), .RD(rd), .WR(wr), .WDATA(wdata));
    runtime_control_register_block #(.BASE_ADDR(BASE))
        runtime_control_register_block_inst (
        .MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .RD(rd), .WR(wr),
        .WDATA(wdata), .RDATA(rdata),
        .PIN_A(st[0]), .PIN_B(st[1]), .PIN_C(st[2]), .PIN_D(st[3]),
        .ICELL_A(st[4]), .ICELL_B(st[5]), .ICELL_C(st[6]),
        .DRV_EN_A(st[7]), .DRV_EN_B(st[8]), .DRV_EN_C(st[9]),
        .DRV_EN_D(st[10]), .NV_MAIN_PROT(st[11]), .NV_SEC_PROT(st[12]),
        .NV_PLACE(st[13]), .OCELL1_Q(st[14]), .OCELL2_Q(st[15]),
        .CELL_DRIVES_A(st[16]), .CELL_DRIVES_B(st[17]),
        .CELL_DRIVES_C(st[18]), .CELL_DRIVES_D(st[19]),
        .MODE_A(outs[0]), .MODE_B(outs[1]), .OUT_A(outs[2]), .OUT_B(outs[3]),
        .DIR_A(outs[4]), .DIR_B(outs[5]), .DRV_A(outs[6]), .DRV_B(outs[7]),
        .OUT_C(outs[8]), .OUT_D(outs[9]), .DIR_C(outs[10]), .DIR_D(outs[11]),
        .DRV_C(outs[12]), .DRV_D(outs[13]), .PWR1(outs[14]), .PWR2(outs[15]),
        .PWR3(outs[16]), .PAGE(outs[17]), .PLACE(outs[18]),
        .OCELL1_LOAD(load1), .OCELL2_LOAD(load2), .OCELL_DATA(cdata));
    function automatic logic [7:0] lfsr();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction
    // expected read byte; masked cell bits read as zero
    function automatic logic [7:0] exp_rd(input logic [7:0] o);
        foreach (ro_ofs[i]) if (ro_ofs[i] == o) return st[i];
        if (o == 8'h20) return st[14] & ~8'(mdl[8'h22]);
        if (o == 8'h21) return st[15] & ~8'(mdl[8'h23]);
        return 8'(mdl[o]);
    endfunction
    // one cycle per byte: set at a falling edge, answer at the next one
    task automatic bus(input logic s, r, w, input logic [7:0] o, d);
        req = '{sel: s, rd: r, wr: w, ofs: o, wdata: d};
        @(negedge mclk);
        rbyte = rdata;
    endtask
    task automatic wr_reg(input logic [7:0] o, d);
        logic [7:0]  m;
        logic [15:0] e;
        bus(1'b1, 1'b0, 1'b1, o, d);
        m = ~8'(mdl[34 + o[0]]);
        e = o[0] ? {m, 8'h00} : {8'h00, m};
        if (o[7:1] == 7'h10) `CHK({load2, load1}, e);
        if (o[7:1] == 7'h10) `CHK(cdata, d);
        foreach (rw_ofs[i])
            if (rw_ofs[i] == o) mdl[o] = o == 8'hC7 ? d | mdl[o] & 2 : d;
    endtask
    task automatic sweep();
        logic [7:0] e;
        for (int o = 0; o < 256; o++) begin
            bus(1'b1, 1'b1, 1'b0, 8'(o), 8'h00);
            `CHK(rbyte, exp_rd(8'(o)));
        end
        foreach (outs[i]) begin
            e = 8'(mdl[rw_ofs[i]]);
            if (i == 2 || i == 3 || i == 8 || i == 9) e &= ~st[i + (i < 4 ? 14 : 10)];
            `CHK(outs[i], e);
        end
        req = '0;
    endtask
    task automatic complete_run();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // reset values, random passes, sticky bit, deselect and a second reset
    initial begin
        foreach (st[i]) st[i] = lfsr();
        foreach (mdl[i]) mdl[i] = 0;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        mdl[8'hE2] = st[13];
        repeat (3) @(negedge mclk);
        sweep();
        for (int p = 0; p < 4; p++) begin
            foreach (st[i]) if (i != 13) st[i] = lfsr();
            repeat (4) @(negedge mclk);
            // only mapped offsets are ever written
            foreach (ro_ofs[i]) wr_reg(ro_ofs[i], lfsr());
            foreach (rw_ofs[i]) wr_reg(rw_ofs[i], lfsr());
            wr_reg(8'h20, lfsr());
            wr_reg(8'h21, lfsr());
            req = '0;
            sweep();
        end
        wr_reg(8'hC7, 8'h02);
        wr_reg(8'hC7, 8'h00);
        bus(1'b0, 1'b1, 1'b1, 8'h06, 8'hFF);
        `CHK(rbyte, 8'h00);
        req = '0;
        sweep();
        rst_n = 1'b0;
        foreach (mdl[i]) mdl[i] = 0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        mdl[8'hE2] = st[13];
        repeat (3) @(negedge mclk);
        sweep();
        complete_run();
    end
    // bounded run: a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        $display("[ERR] %0t run did not finish", $time);
        complete_run();
    end
endmodule
